// File: rtl/gdfm_top.sv
// Notes on behaviour
// - threshold pin picks trip 0.06..0.96 V; grounded lowest, open 0.48 V
// - pin tied to analog regulator rail turns drain-source monitoring off
// - supply lockout: bridge and pump off, fault low, supply flag set
// - supply recovery resumes and releases fault; flag sticks until clear
// - supply lockout keeps settings; only logic lockout resets them
// - logic lockout resets all logic and settings, fault held low
// - pump lockout: bridge off, fault low, pump flag set, pump keeps running
// - pump recovery resumes and releases fault; flag sticks until clear
// - driven FET tripped beyond deglitch: bridge off, fault low, overcurrent flag
// - after overcurrent, drivers and fault released when retry time ends
// - persisting overcurrent repeats the shutdown and retry cycle
// - overcurrent flag stays set until a clear-fault write
// - sense comparator excess also sets overcurrent flag and pulls fault low
// - gate not following command at window end: gate fault, bridge off
// - gate fault recovers after retry time; flag sticks until clear
// - over-temperature: bridge, pump, analog regulator off, fault low, flag set
// - over-temperature clearing resumes and releases fault; flag sticks
// - watchdog enable resets to 0; controller sets it by writing 1
// - enabled watchdog counts selected interval; read of 0x00 restarts it
// - after expiry, flag and halt stay until clear-fault written 1
// - pump and analog regulator run except on supply lockout, over-temp and logic lockout
`timescale 1ns/10ps
`default_nettype none
`include "gdfm_consts.svh"

module gdfm_top #(
  parameter int RETRY_US = 4000,
  parameter int WDOG_PULSE_US = 64,
  parameter int WDOG_INT0_MS = 10,
  parameter int WDOG_INT1_MS = 20,
  parameter int WDOG_INT2_MS = 50,
  parameter int WDOG_INT3_MS = 100
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic logic_lockout,
  input wire logic supply_lockout,
  input wire logic pump_lockout,
  input wire logic over_temp_shutdown,
  input wire logic [2:0] drain_source_thresh_pin,
  input wire logic [3:0] ds_trip,
  input wire logic sense_trip,
  input wire logic [3:0] gate_cmd,
  input wire logic [3:0] gate_high,
  input wire gdfm_pkg::gdfm_axil_req_t axi_req,
  output gdfm_pkg::gdfm_axil_rsp_t axi_rsp,
  output logic fault_out_n,
  output logic wdog_fault_out_n,
  output logic bridge_en,
  output logic pump_en,
  output logic analog_reg_en,
  output logic digital_reg_en,
  output logic [2:0] ds_trip_sel,
  output logic ds_monitor_en
);
  import gdfm_pkg::*;

  // derived cycle counts; least times round up, longest round down
  localparam int DEG_CYC = (`GDFM_OCP_DEGLITCH_NS * `GDFM_CLK_MHZ + 999) / 1000;
  localparam int DRIVE_CYC = (`GDFM_DRIVE_NS * `GDFM_CLK_MHZ) / 1000;
  localparam int RETRY_CYC = RETRY_US * `GDFM_CLK_MHZ;
  localparam int PULSE_CYC = WDOG_PULSE_US * `GDFM_CLK_MHZ;
  localparam int WD0_CYC = WDOG_INT0_MS * 1000 * `GDFM_CLK_MHZ;
  localparam int WD1_CYC = WDOG_INT1_MS * 1000 * `GDFM_CLK_MHZ;
  localparam int WD2_CYC = WDOG_INT2_MS * 1000 * `GDFM_CLK_MHZ;
  localparam int WD3_CYC = WDOG_INT3_MS * 1000 * `GDFM_CLK_MHZ;

  typedef struct packed {
    gdfm_prot_state_t pst;
    logic [24:0] retry_cnt;
    logic [24:0] wd_cnt;
    logic [15:0] pulse_cnt;
    logic wdog_enable_bit;
    logic [1:0] wd_sel;
    gdfm_flags_t flags;
    logic [3:0] cmd_d;
    logic [15:0] drive_cnt;
    logic drive_busy;
    logic aw_got;
    logic w_got;
    logic [31:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    gdfm_axil_rsp_t rsp;
    logic fault_n;
    logic wdf_n;
    logic bridge;
    logic pump;
    logic analog;
    logic digital;
  } gdfm_state_t;

  localparam gdfm_state_t STATE_RST = '{pst: st_run, wdf_n: 1'b1, default: '0};

  gdfm_state_t s_r;
  gdfm_state_t s_nxt;
  logic [3:0] deg_out;
  logic [9:0] trip_mv;

  // pin decoder; the analog comparators use the select code
  gdfm_thresh_dec u_thresh (
    .clock(clock),
    .rst(rst || logic_lockout),
    .level(drain_source_thresh_pin),
    .trip_sel(ds_trip_sel),
    .mon_en(ds_monitor_en),
    .trip_mv(trip_mv)
  );

  // one deglitch filter per FET, armed only while that FET is driven
  for (genvar i = 0; i < 4; i++) begin : g_deg
    gdfm_deglitch #(.LIMIT(DEG_CYC)) u_deg (
      .clock(clock),
      .rst(rst || logic_lockout),
      .in_lvl(ds_trip[i] && gate_cmd[i] && ds_monitor_en && s_r.bridge),
      .out_lvl(deg_out[i])
    );
  end

  function automatic logic [24:0] wd_interval(input logic [1:0] sel);
    logic [24:0] v;
    v = 25'(WD0_CYC - 1);
    unique case (sel)
      2'h0: v = 25'(WD0_CYC - 1);
      2'h1: v = 25'(WD1_CYC - 1);
      2'h2: v = 25'(WD2_CYC - 1);
      2'h3: v = 25'(WD3_CYC - 1);
    endcase
    return v;
  endfunction : wd_interval

  logic oc_ev;
  logic gf_ev;
  logic wd_expire;
  logic do_write;
  logic ctl_write;
  logic clr;
  logic rd_take;
  logic rd_svc;
  logic lock;
  gdfm_flags_t present;
  logic [31:0] rd_val;
  logic rd_ok;

  always_comb begin
    s_nxt = s_r;
    lock = supply_lockout || pump_lockout || over_temp_shutdown;

    // overcurrent from filtered drain-source trips or the sense comparator
    oc_ev = (|deg_out) || sense_trip;

    // gate watch: every command change opens a fresh drive window
    gf_ev = 1'b0;
    s_nxt.cmd_d = gate_cmd;
    if (gate_cmd != s_r.cmd_d) begin
      s_nxt.drive_busy = 1'b1;
      s_nxt.drive_cnt = 16'(DRIVE_CYC - 1);
    end else if (s_r.drive_busy) begin
      if (s_r.drive_cnt == 16'h0000) begin
        s_nxt.drive_busy = 1'b0;
        gf_ev = s_r.bridge && (gate_high != gate_cmd);
      end else begin
        s_nxt.drive_cnt = s_r.drive_cnt - 16'h0001;
      end
    end

    // axi write: address and data taken in either order, answered after both
    if (axi_req.awvalid && s_r.rsp.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.waddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_r.rsp.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = axi_req.wdata;
      s_nxt.wstrb = axi_req.wstrb;
    end
    if (s_r.rsp.bvalid && axi_req.bready) begin
      s_nxt.rsp.bvalid = 1'b0;
    end
    do_write = s_r.aw_got && s_r.w_got && !s_r.rsp.bvalid;
    ctl_write = do_write && (s_r.waddr == `GDFM_ADDR_CONTROL) && s_r.wstrb[0];
    clr = ctl_write && s_r.wdata[`GDFM_CTL_CLEAR];
    if (do_write) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.rsp.bvalid = 1'b1;
      s_nxt.rsp.bresp = (s_r.waddr == `GDFM_ADDR_CONTROL || s_r.waddr == `GDFM_ADDR_STATUS ||
                         s_r.waddr == `GDFM_ADDR_CONFIG) ? `GDFM_RESP_OKAY : `GDFM_RESP_SLVERR;
    end
    if (ctl_write) begin
      s_nxt.wd_sel = s_r.wdata[`GDFM_CTL_WDOG_SEL_LSB +: 2];
      s_nxt.wdog_enable_bit = s_r.wdata[`GDFM_CTL_WDOG_EN];
      // a fresh enable loads the interval picked in the same write
      if (s_r.wdata[`GDFM_CTL_WDOG_EN] && !s_r.wdog_enable_bit) begin
        s_nxt.wd_cnt = wd_interval(s_r.wdata[`GDFM_CTL_WDOG_SEL_LSB +: 2]);
      end
    end
    s_nxt.rsp.awready = !s_nxt.aw_got && !s_nxt.rsp.bvalid;
    s_nxt.rsp.wready = !s_nxt.w_got && !s_nxt.rsp.bvalid;

    // axi read: one cycle from the address handshake to rvalid
    if (s_r.rsp.rvalid && axi_req.rready) begin
      s_nxt.rsp.rvalid = 1'b0;
    end
    rd_take = axi_req.arvalid && s_r.rsp.arready;
    rd_svc = rd_take && (axi_req.araddr == `GDFM_ADDR_STATUS);
    rd_ok = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (axi_req.araddr)
      `GDFM_ADDR_STATUS: begin
        rd_val[5:0] = s_r.flags;
        rd_val[`GDFM_ST_LIVE_LSB +: 5] = {s_r.pst == st_halt, s_r.pst == st_retry,
                                          over_temp_shutdown, pump_lockout, supply_lockout};
        rd_val[`GDFM_ST_FAULT_PIN] = !s_r.fault_n;
      end
      `GDFM_ADDR_CONTROL: begin
        rd_val[`GDFM_CTL_WDOG_EN] = s_r.wdog_enable_bit;
        rd_val[`GDFM_CTL_WDOG_SEL_LSB +: 2] = s_r.wd_sel; // clear bit reads 0
      end
      `GDFM_ADDR_CONFIG: begin
        rd_val[2:0] = ds_trip_sel;
        rd_val[`GDFM_CFG_MON_EN] = ds_monitor_en;
        rd_val[`GDFM_CFG_MV_LSB +: 10] = trip_mv;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
    if (rd_take) begin
      s_nxt.rsp.rvalid = 1'b1;
      s_nxt.rsp.rdata = rd_val;
      s_nxt.rsp.rresp = rd_ok ? `GDFM_RESP_OKAY : `GDFM_RESP_SLVERR;
    end
    s_nxt.rsp.arready = !s_nxt.rsp.rvalid;

    // watchdog countdown; a service read always beats expiry
    wd_expire = 1'b0;
    if (s_r.wdog_enable_bit) begin
      if (rd_svc) begin
        s_nxt.wd_cnt = wd_interval(s_r.wd_sel);
      end else if (s_r.wd_cnt == 25'h0000000) begin
        wd_expire = 1'b1;
      end else begin
        s_nxt.wd_cnt = s_r.wd_cnt - 25'h0000001;
      end
    end

    // watchdog pin pulse, fixed length from the expiry cycle
    if (!s_r.wdf_n) begin
      if (s_r.pulse_cnt == 16'h0000) begin
        s_nxt.wdf_n = 1'b1;
      end else begin
        s_nxt.pulse_cnt = s_r.pulse_cnt - 16'h0001;
      end
    end
    if (wd_expire) begin
      s_nxt.wdog_enable_bit = 1'b0; // expiry wins over a same-cycle enable write
      s_nxt.wdf_n = 1'b0;
      s_nxt.pulse_cnt = 16'(PULSE_CYC - 1);
    end

    // shutdown and retry sequencing
    unique case (s_r.pst)
      st_run: begin
        if (oc_ev || gf_ev) begin
          s_nxt.pst = st_retry;
          s_nxt.retry_cnt = 25'(RETRY_CYC - 1);
        end
      end
      st_retry: begin
        // on release a still-present fault trips again, repeating the cycle
        if (s_r.retry_cnt == 25'h0000000) begin
          s_nxt.pst = st_run;
        end else begin
          s_nxt.retry_cnt = s_r.retry_cnt - 25'h0000001;
        end
      end
      st_halt: begin
        if (clr) begin
          s_nxt.pst = st_run;
        end
      end
    endcase
    if (wd_expire) begin
      s_nxt.pst = st_halt;
    end

    // sticky flags: clear drops only absent conditions, and a set beats the clear
    present = '{wdog: 1'b0, over_temp: over_temp_shutdown, gate: gf_ev || s_r.pst == st_retry,
                overcurrent: oc_ev || s_r.pst == st_retry, pump_uv: pump_lockout,
                supply_uv: supply_lockout};
    if (clr) begin
      s_nxt.flags = s_r.flags & present;
    end
    s_nxt.flags.supply_uv = s_nxt.flags.supply_uv || supply_lockout;
    s_nxt.flags.pump_uv = s_nxt.flags.pump_uv || pump_lockout;
    s_nxt.flags.overcurrent = s_nxt.flags.overcurrent || oc_ev;
    s_nxt.flags.gate = s_nxt.flags.gate || gf_ev;
    s_nxt.flags.over_temp = s_nxt.flags.over_temp || over_temp_shutdown;
    s_nxt.flags.wdog = s_nxt.flags.wdog || wd_expire;

    // drive outputs follow lockout levels directly, so recovery is automatic
    s_nxt.bridge = !lock && (s_nxt.pst == st_run);
    s_nxt.pump = !(supply_lockout || over_temp_shutdown);
    s_nxt.analog = !(supply_lockout || over_temp_shutdown);
    s_nxt.digital = 1'b1;
    s_nxt.fault_n = !lock && (s_nxt.pst == st_run);
  end

  // logic lockout acts like reset; supply lockout leaves settings alone
  always_ff @(posedge clock) begin
    if (rst || logic_lockout) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign axi_rsp = s_r.rsp;
  assign fault_out_n = s_r.fault_n;
  assign wdog_fault_out_n = s_r.wdf_n;
  assign bridge_en = s_r.bridge;
  assign pump_en = s_r.pump;
  assign analog_reg_en = s_r.analog;
  assign digital_reg_en = s_r.digital;
endmodule : gdfm_top

`default_nettype wire

// File: rtl/gdfm_consts.svh
`ifndef GDFM_CONSTS_SVH
`define GDFM_CONSTS_SVH

// clock rate
`define GDFM_CLK_MHZ 200

// register byte addresses
`define GDFM_ADDR_STATUS 32'h0000_0000
`define GDFM_ADDR_CONTROL 32'h0000_0004
`define GDFM_ADDR_CONFIG 32'h0000_0008

// control register fields
`define GDFM_CTL_WDOG_EN 0
`define GDFM_CTL_WDOG_SEL_LSB 1
`define GDFM_CTL_CLEAR 3

// status register fields (flags sit in bits 5:0)
`define GDFM_ST_LIVE_LSB 8
`define GDFM_ST_FAULT_PIN 16

// config register fields
`define GDFM_CFG_MON_EN 3
`define GDFM_CFG_MV_LSB 4

// axi responses
`define GDFM_RESP_OKAY 2'h0
`define GDFM_RESP_SLVERR 2'h2

// threshold pin level codes from the pin's window comparators
`define GDFM_LVL_GND 3'h0
`define GDFM_LVL_R33K 3'h1
`define GDFM_LVL_R200K 3'h2
`define GDFM_LVL_OPEN 3'h3
`define GDFM_LVL_R68K_ANALOG_REGULATOR 3'h4
`define GDFM_LVL_ANALOG_REGULATOR 3'h5

// trip levels in millivolts
`define GDFM_TRIP_MV_0 10'h03c
`define GDFM_TRIP_MV_1 10'h078
`define GDFM_TRIP_MV_2 10'h0f0
`define GDFM_TRIP_MV_3 10'h1e0
`define GDFM_TRIP_MV_4 10'h3c0

// timing, in the units named
`define GDFM_OCP_DEGLITCH_NS 4000
`define GDFM_DRIVE_NS 2000

`endif

// File: rtl/gdfm_pkg.sv
package gdfm_pkg;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } gdfm_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } gdfm_axil_rsp_t;

  // sticky fault flags, bit 5 downward
  typedef struct packed {
    logic wdog;
    logic over_temp;
    logic gate;
    logic overcurrent;
    logic pump_uv;
    logic supply_uv;
  } gdfm_flags_t;

  typedef enum logic [1:0] {st_run, st_retry, st_halt} gdfm_prot_state_t;

endpackage : gdfm_pkg

// File: rtl/gdfm_deglitch.sv
`timescale 1ns/10ps
`default_nettype none

// output rises once the input has stayed high for more than limit cycles
module gdfm_deglitch #(
  parameter int LIMIT = 800
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_lvl,
  output logic out_lvl
);
  typedef struct packed {
    logic [15:0] cnt;
    logic out;
  } gdfm_dg_state_t;

  gdfm_dg_state_t s_r;
  gdfm_dg_state_t s_nxt;

  // any low cycle restarts the count, so short spikes never reach the output
  always_comb begin
    s_nxt = s_r;
    if (!in_lvl) begin
      s_nxt.cnt = 16'h0000;
    end else if (s_r.cnt != 16'(LIMIT)) begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
    s_nxt.out = in_lvl && (s_r.cnt == 16'(LIMIT));
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign out_lvl = s_r.out;
endmodule : gdfm_deglitch

`default_nettype wire

// File: rtl/gdfm_thresh_dec.sv
`timescale 1ns/10ps
`default_nettype none
`include "gdfm_consts.svh"

// six-level threshold pin to trip select, monitor enable and level in mv
module gdfm_thresh_dec (
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] level,
  output logic [2:0] trip_sel,
  output logic mon_en,
  output logic [9:0] trip_mv
);
  typedef struct packed {
    logic [2:0] sel;
    logic en;
    logic [9:0] mv;
  } gdfm_td_state_t;

  gdfm_td_state_t s_r;
  gdfm_td_state_t s_nxt;

  // unknown codes fall back to the open-pin setting
  always_comb begin
    s_nxt = s_r;
    s_nxt.en = 1'b1;
    unique case (level)
      `GDFM_LVL_GND: begin
        s_nxt.sel = 3'h0;
        s_nxt.mv = `GDFM_TRIP_MV_0;
      end
      `GDFM_LVL_R33K: begin
        s_nxt.sel = 3'h1;
        s_nxt.mv = `GDFM_TRIP_MV_1;
      end
      `GDFM_LVL_R200K: begin
        s_nxt.sel = 3'h2;
        s_nxt.mv = `GDFM_TRIP_MV_2;
      end
      `GDFM_LVL_R68K_ANALOG_REGULATOR: begin
        s_nxt.sel = 3'h4;
        s_nxt.mv = `GDFM_TRIP_MV_4;
      end
      `GDFM_LVL_ANALOG_REGULATOR: begin
        s_nxt.sel = 3'h3;
        s_nxt.mv = 10'h000;
        s_nxt.en = 1'b0;
      end
      default: begin
        s_nxt.sel = 3'h3;
        s_nxt.mv = `GDFM_TRIP_MV_3;
      end
    endcase
  end

  // reset value is the open-pin setting with the monitor on
  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '{sel: 3'h3, en: 1'b1, mv: `GDFM_TRIP_MV_3};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign trip_sel = s_r.sel;
  assign mon_en = s_r.en;
  assign trip_mv = s_r.mv;
endmodule : gdfm_thresh_dec

`default_nettype wire

// File: verification/gdfm_top_properties.sv
`timescale 1ns/10ps
`default_nettype none

// pin relations of the fault manager; lockouts show one edge after their cause
module gdfm_top_properties (
  input wire logic clock,
  input wire logic rst,
  input wire logic logic_lockout,
  input wire logic supply_lockout,
  input wire logic pump_lockout,
  input wire logic over_temp_shutdown,
  input wire logic sense_trip,
  input wire logic [2:0] drain_source_thresh_pin,
  input wire gdfm_pkg::gdfm_axil_req_t axi_req,
  input wire gdfm_pkg::gdfm_axil_rsp_t axi_rsp,
  input wire logic fault_out_n,
  input wire logic bridge_en,
  input wire logic pump_en,
  input wire logic analog_reg_en,
  input wire logic [2:0] ds_trip_sel,
  input wire logic ds_monitor_en
);
  import gdfm_pkg::*;
  logic [1:0] live_r;

  // outputs still show reset values for two edges after rst or logic lockout falls
  always_ff @(posedge clock) begin
    if (rst || logic_lockout) begin
      live_r <= 2'h0;
    end else begin
      live_r <= {live_r[0], 1'b1};
    end
  end

  // logic lockout resets the design just like rst, so both silence the checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || logic_lockout || !live_r[1]);

  a_supply_off: assert property (
    supply_lockout |=> !bridge_en && !pump_en && !analog_reg_en && !fault_out_n)
    else $error("supply lockout left an output on");
  a_pump_lock: assert property (pump_lockout |=> !bridge_en && !fault_out_n)
    else $error("pump lockout left the bridge on");
  a_pump_kept: assert property (
    !supply_lockout && !over_temp_shutdown |=> pump_en && analog_reg_en)
    else $error("pump or regulator stopped without cause");
  a_temp_off: assert property (
    over_temp_shutdown |=> !bridge_en && !pump_en && !analog_reg_en && !fault_out_n)
    else $error("over temperature left an output on");
  a_sense_trip: assert property (sense_trip |-> ##[1:2] (!fault_out_n && !bridge_en))
    else $error("sense trip did not shut down");
  a_fault_live: assert property (
    fault_out_n |-> !$past(supply_lockout || pump_lockout || over_temp_shutdown))
    else $error("fault released while a lockout was live");
  // the pin code passes one register stage before it shows
  a_trip_level: assert property ($stable(drain_source_thresh_pin) [*3] |->
    ds_trip_sel == ((drain_source_thresh_pin < 3'h5) ? drain_source_thresh_pin : 3'h3))
    else $error("trip select does not match the pin");
  a_monitor_off: assert property ($stable(drain_source_thresh_pin) [*3] |->
    ds_monitor_en == (drain_source_thresh_pin != 3'h5))
    else $error("monitor enable does not match the pin");
  a_read_answer: assert property (
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready)
    else $error("read not answered one cycle after it was taken");

  c_temp: cover property (over_temp_shutdown ##1 !over_temp_shutdown);
  c_sense: cover property (sense_trip);
  c_service: cover property (axi_req.arvalid && axi_rsp.arready && axi_req.araddr == 32'h0);
  c_mon_off: cover property (ds_monitor_en ##1 !ds_monitor_en);
endmodule : gdfm_top_properties

bind gdfm_top gdfm_top_properties i_gdfm_top_properties (.*);

`default_nettype wire

// File: verification/gdfm_fet_model.sv
`timescale 1ns/10ps
`default_nettype none

// four external fets: gates follow the driver after a slew delay
module gdfm_fet_model #(
  parameter int SLEW = 20
) (
  input wire logic clock,
  input wire logic [3:0] gate_cmd,
  input wire logic bridge_en,
  input wire logic [3:0] stuck,
  input wire logic overload,
  output logic [3:0] gate_high,
  output logic [3:0] ds_trip
);
  logic [3:0] tgt;
  logic [3:0] tgt_last = 4'h0;
  int age = 0;
  initial gate_high = 4'h0;
  // a stuck gate never charges; that is the only wrong answer the bench commands
  assign tgt = gate_cmd & {4{bridge_en}} & ~stuck;
  // only a conducting fet shows a drain-source drop
  assign ds_trip = gate_high & {4{overload}};
  // gate settles slew plus two cycles after its drive last changed
  always @(posedge clock) begin
    tgt_last <= tgt;
    age <= (tgt != tgt_last) ? 0 : age + 1;
    if (age == SLEW) gate_high <= tgt_last;
  end
endmodule : gdfm_fet_model

`default_nettype wire

// File: verification/test_gate_driver_fault_manager.sv
`timescale 1ns/10ps
`default_nettype none
`include "gdfm_consts.svh"

module test_gate_driver_fault_manager;
  import gdfm_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic logic_lockout = 1'b0;
  logic [2:0] lock = 3'h0;
  logic [2:0] pin = 3'h3;
  logic sense_trip = 1'b0;
  logic [3:0] gate_cmd = 4'h0;
  logic [3:0] stuck = 4'h0;
  logic overload = 1'b0;
  logic [3:0] gate_high;
  logic [3:0] ds_trip;
  gdfm_axil_req_t req = '0;
  gdfm_axil_rsp_t rsp;
  logic fault_out_n, wdog_fault_out_n, bridge_en, pump_en, analog_reg_en, digital_reg_en;
  logic ds_monitor_en;
  logic [2:0] ds_trip_sel;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  logic [1:0] wr_resp;
  int miscompares = 0;
  int num_checks = 0;
  int mflags = 0;
  int mctl = 0;
  int cnt;
  int sel;
  int fbit[3] = '{1, 2, 16};

  // short retry and pulse, 200 clocks each, so each fault cycle stays within about a thousand clocks
  gdfm_top #(.RETRY_US(1), .WDOG_PULSE_US(1), .WDOG_INT0_MS(1), .WDOG_INT1_MS(1),
    .WDOG_INT2_MS(1), .WDOG_INT3_MS(1)) i_gdfm_top (
    .clock, .rst, .logic_lockout, .supply_lockout(lock[0]), .pump_lockout(lock[1]),
    .over_temp_shutdown(lock[2]), .drain_source_thresh_pin(pin), .ds_trip, .sense_trip,
    .gate_cmd, .gate_high, .axi_req(req), .axi_rsp(rsp), .fault_out_n, .wdog_fault_out_n,
    .bridge_en, .pump_en, .analog_reg_en, .digital_reg_en, .ds_trip_sel, .ds_monitor_en);

  gdfm_fet_model i_gdfm_fet_model (.clock, .gate_cmd, .bridge_en, .stuck, .overload,
    .gate_high, .ds_trip);

  initial forever #2.5 clock = ~clock;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic hang;
    miscompares++;
    finish_test;
  endtask : hang

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // ready and valid are looked at mid-cycle, where they equal what the next edge samples
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge clock);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge clock);
      aw = rsp.awready;
      w = rsp.wready;
      b = rsp.bvalid;
      wr_resp = rsp.bresp;
      @(posedge clock);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
      if (b) req.bready <= 1'b0;
      if (b) return;
    end
    hang;
  endtask : wr

  task automatic rd(input logic [31:0] a);
    logic ar, rv;
    @(posedge clock);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge clock);
      ar = rsp.arready;
      rv = rsp.rvalid;
      rd_data = rsp.rdata;
      rd_resp = rsp.rresp;
      @(posedge clock);
      if (ar) req.arvalid <= 1'b0;
      if (rv) req.rready <= 1'b0;
      if (rv) return;
    end
    hang;
  endtask : rd

  task automatic wait_fault(input logic lvl);
    for (cnt = 0; cnt < 3000; cnt++) begin
      @(negedge clock);
      if (fault_out_n === lvl) return;
    end
    hang;
  endtask : wait_fault

  // flags compared against the model, which keeps only what the events imply
  task automatic chk_flags;
    rd(`GDFM_ADDR_STATUS);
    chk(rd_data[5:0], mflags[5:0]);
  endtask : chk_flags

  task automatic clr(input int live);
    wr(`GDFM_ADDR_CONTROL, mctl | 32'h8);
    mflags = mflags & live;
  endtask : clr

  // main sequence: one scenario after another, all on one clock
  initial begin
    void'($urandom(77));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    tick(2);
    @(negedge clock);
    chk(fault_out_n, 1);
    chk(wdog_fault_out_n, 1);
    chk(digital_reg_en, 1);
    rd(`GDFM_ADDR_CONTROL);
    chk(rd_data, mctl);
    rd(32'h0000_0010);
    chk(rd_resp, `GDFM_RESP_SLVERR);
    wr(32'h0000_0010, 32'h0000_0008);
    chk(wr_resp, `GDFM_RESP_SLVERR);
    wr(`GDFM_ADDR_STATUS, 32'h0000_003f);
    chk(wr_resp, `GDFM_RESP_OKAY);
    chk_flags;
    $display("reset test done");
    for (int p = 0; p < 8; p++) begin
      pin <= p[2:0];
      tick(4);
      rd(`GDFM_ADDR_CONFIG);
      sel = (p < 5) ? p : 3;
      chk(rd_data[3:0], {p != 5, sel[2:0]});
      if (p != 5) chk(rd_data[13:4], 60 << sel);
    end
    $display("pin test done");
    wr(`GDFM_ADDR_CONTROL, 32'h4);
    mctl = 4;
    for (int i = 0; i < 3; i++) begin
      lock <= 3'h1 << i;
      tick(2);
      @(negedge clock);
      chk(fault_out_n, 0);
      chk(bridge_en, 0);
      chk(pump_en, i == 1);
      chk(analog_reg_en, i == 1);
      mflags = mflags | fbit[i];
      clr(fbit[i]);
      chk_flags;
      lock <= 3'h0;
      tick(2);
      @(negedge clock);
      chk(fault_out_n, 1);
      chk_flags;
      rd(`GDFM_ADDR_CONTROL);
      chk(rd_data, mctl);
      clr(0);
      chk_flags;
    end
    $display("lockout test done");
    pin <= 3'h0;
    gate_cmd <= 4'h1 << ($urandom % 4);
    tick(450);
    overload <= 1'b1;
    tick(100 + $urandom % 600);
    overload <= 1'b0;
    tick(3);
    @(negedge clock);
    chk(fault_out_n, 1);
    @(posedge clock);
    overload <= 1'b1;
    wait_fault(0);
    chk(cnt >= 798 && cnt <= 806, 1);
    mflags = mflags | 4;
    wait_fault(1);
    chk(cnt >= 196 && cnt <= 206, 1);
    wait_fault(0);
    chk(cnt >= 812 && cnt <= 840, 1);
    @(posedge clock);
    overload <= 1'b0;
    wait_fault(1);
    tick(50);
    @(negedge clock);
    chk(fault_out_n, 1);
    chk_flags;
    clr(0);
    chk_flags;
    $display("overcurrent test done");
    sense_trip <= 1'b1;
    @(posedge clock);
    sense_trip <= 1'b0;
    wait_fault(0);
    chk(cnt <= 3, 1);
    mflags = mflags | 4;
    wait_fault(1);
    chk_flags;
    stuck <= 4'h1 << ($urandom % 2);
    gate_cmd <= 4'h3;
    wait_fault(0);
    chk(cnt >= 395 && cnt <= 410, 1);
    mflags = mflags | 8;
    wait_fault(1);
    chk(cnt >= 196 && cnt <= 206, 1);
    chk_flags;
    stuck <= 4'h0;
    gate_cmd <= 4'h0;
    tick(450);
    clr(0);
    chk_flags;
    $display("sense and gate test done");
    wr(`GDFM_ADDR_CONTROL, 32'h1);
    mctl = 1;
    rd(`GDFM_ADDR_CONTROL);
    chk(rd_data, mctl);
    repeat (3) rd(`GDFM_ADDR_STATUS);
    @(negedge clock);
    chk(wdog_fault_out_n, 1);
    $display("watchdog test done");
    wr(`GDFM_ADDR_CONTROL, 32'h4);
    mflags = 1;
    lock <= 3'h1;
    @(posedge clock);
    lock <= 3'h0;
    logic_lockout <= 1'b1;
    tick(2);
    @(negedge clock);
    chk(fault_out_n, 0);
    @(posedge clock);
    logic_lockout <= 1'b0;
    mctl = 0;
    mflags = 0;
    rd(`GDFM_ADDR_CONTROL);
    chk(rd_data, mctl);
    chk_flags;
    $display("logic lockout test done");
    finish_test;
  end
endmodule : test_gate_driver_fault_manager

`default_nettype wire
